// *** include/ipr_pkg.sv ***
// Package for the interrupt priority register group (sources 6 to 12).
// Assumes a 16-bit register port with a 3-bit register index.
package ipr_pkg;

    // Sizes of the register group
    localparam int unsigned IPR_NSRC = 16;
    localparam int unsigned IPR_NREG = 7;
    localparam int unsigned IPR_FW = 3;
    localparam int unsigned IPR_DW = 16;
    localparam int unsigned IPR_AW = 3;

    typedef logic [IPR_FW-1:0] ipr_prio_t;
    typedef logic [IPR_DW-1:0] ipr_word_t;
    typedef logic [IPR_AW-1:0] ipr_addr_t;
    typedef logic [3:0] ipr_src_t;

    // Register indices on the register port
    localparam ipr_addr_t IPR_OFF_TIMER4_COMPARE34 = 3'h0;
    localparam ipr_addr_t IPR_OFF_UART2_EXT2_TIMER5 = 3'h1;
    localparam ipr_addr_t IPR_OFF_SECOND_SPI = 3'h2;
    localparam ipr_addr_t IPR_OFF_CAPTURE345 = 3'h3;
    localparam ipr_addr_t IPR_OFF_COMPARE5 = 3'h4;
    localparam ipr_addr_t IPR_OFF_PARALLEL_PORT = 3'h5;
    localparam ipr_addr_t IPR_OFF_SECOND_I2C = 3'h6;

    // Implemented bits of each register; all others read zero
    localparam ipr_word_t IPR_MASK_TIMER4_COMPARE34 = 16'h7770;
    localparam ipr_word_t IPR_MASK_UART2_EXT2_TIMER5 = 16'h7777;
    localparam ipr_word_t IPR_MASK_SECOND_SPI = 16'h0077;
    localparam ipr_word_t IPR_MASK_CAPTURE345 = 16'h7770;
    localparam ipr_word_t IPR_MASK_COMPARE5 = 16'h0070;
    localparam ipr_word_t IPR_MASK_PARALLEL_PORT = 16'h0070;
    localparam ipr_word_t IPR_MASK_SECOND_I2C = 16'h0770;

    // Field value after reset: pattern 1,0,0 which is level 4
    localparam ipr_prio_t IPR_FIELD_RST = 3'h4;
    // Code that switches a source off
    localparam ipr_prio_t IPR_PRIO_OFF = 3'h0;

    // Source order: timer4, compare4, compare3, uart2 tx, uart2 rx,
    // ext irq2, timer5, spi2 event, spi2 fault, capture5, capture4,
    // capture3, compare5, parallel port, i2c2 master, i2c2 slave.
    // Register holding each source
    localparam int unsigned IPR_SRC_REG [IPR_NSRC] = '{
        0, 0, 0, 1, 1, 1, 1, 2, 2, 3, 3, 3, 4, 5, 6, 6};
    // Least significant bit of each source field
    localparam int unsigned IPR_SRC_LSB [IPR_NSRC] = '{
        12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 8, 4, 4, 4, 8, 4};

    // Implemented-bit mask of a register index; zero when unmapped
    function automatic ipr_word_t ipr_mask(input ipr_addr_t idx);
        case (idx)
            IPR_OFF_TIMER4_COMPARE34: ipr_mask = IPR_MASK_TIMER4_COMPARE34;
            IPR_OFF_UART2_EXT2_TIMER5: ipr_mask = IPR_MASK_UART2_EXT2_TIMER5;
            IPR_OFF_SECOND_SPI: ipr_mask = IPR_MASK_SECOND_SPI;
            IPR_OFF_CAPTURE345: ipr_mask = IPR_MASK_CAPTURE345;
            IPR_OFF_COMPARE5: ipr_mask = IPR_MASK_COMPARE5;
            IPR_OFF_PARALLEL_PORT: ipr_mask = IPR_MASK_PARALLEL_PORT;
            IPR_OFF_SECOND_I2C: ipr_mask = IPR_MASK_SECOND_I2C;
            default: ipr_mask = 16'h0000;
        endcase
    endfunction

    // True when the index names one of the seven registers
    function automatic logic ipr_mapped(input ipr_addr_t idx);
        ipr_mapped = (ipr_mask(idx) != 16'h0000);
    endfunction

endpackage

// *** include/ipr_bank_if.sv ***
// Interface between the register port logic and the field bank.
// Assumes one clock; all members are same-domain signals.
`timescale 1ns/1ps
`default_nettype none
interface ipr_bank_if
    import ipr_pkg::*;
#(
    parameter int unsigned NSRC = IPR_NSRC
) ();
    // Per-source write strobe and value to store
    logic [NSRC-1:0] wr;
    ipr_prio_t wval [NSRC];
    // Stored priority code of each source
    ipr_prio_t prio [NSRC];
    // Current request of each source, already gated by its priority
    logic [NSRC-1:0] req;

    modport owner (input wr, input wval, output prio);
    modport user (output wr, output wval, input prio);
    modport view (input prio, input req);
endinterface
`default_nettype wire

// *** verilog/ipr_prio_bank.sv ***
// Bank of per-source priority fields, one 3-bit register each.
// Assumes write strobes arrive already decoded and masked.
`timescale 1ns/1ps
`default_nettype none
module ipr_prio_bank
    import ipr_pkg::*;
#(
    parameter int unsigned NSRC = IPR_NSRC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    ipr_bank_if.owner bank
);

    ////////////////////////////////////////////////////////////////////
    // One field per source; reset puts every source at level 4
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_fld
            always_ff @(posedge clk_i) begin
                if (!rst_b_i) begin
                    bank.prio[g] <= IPR_FIELD_RST;
                end else if (bank.wr[g]) begin
                    bank.prio[g] <= bank.wval[g];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// *** verilog/ipr_pick.sv ***
// Finds the highest priority among the gated source requests.
// Assumes requests are already cleared for disabled sources.
`timescale 1ns/1ps
`default_nettype none
module ipr_pick
    import ipr_pkg::*;
#(
    parameter int unsigned NSRC = IPR_NSRC
) (
    ipr_bank_if.view bank,
    output logic any_o,
    output ipr_prio_t level_o,
    output ipr_src_t src_o
);

    ////////////////////////////////////////////////////////////////////
    // Larger code wins; on a tie the lower source index is kept,
    // because only a strictly higher code replaces the holder.
    always_comb begin
        any_o = 1'b0;
        level_o = IPR_PRIO_OFF;
        src_o = 4'h0;
        for (int i = 0; i < NSRC; i++) begin
            if (bank.req[i] && (!any_o || bank.prio[i] > level_o)) begin
                any_o = 1'b1;
                level_o = bank.prio[i];
                src_o = ipr_src_t'(i);
            end
        end
    end

endmodule
`default_nettype wire

// *** verilog/ipr_top.sv ***
// Interrupt priority registers for sources of groups 6 to 12.
// Assumes a simple register port on the system clock and source
// flags produced by same-clock peripheral logic.
//
// Summary of operation
// - Field code 111 gives the source level 7, the highest level.
// - Codes 001 to 111 map to levels 1 to 7 in rising order.
// - Field code 000 disables the source; it never raises a request.
// - Every unimplemented bit reads back as zero.
// - Reset loads each field with bits one, zero, zero.
// - Fields are read and written; a read returns the last write.
// - Register 0: timer4 14-12, compare4 10-8, compare3 6-4.
// - Register 1: uart2 tx 14-12, rx 10-8, ext irq2 6-4, timer5 2-0.
// - Register 2: spi2 event 6-4, spi2 fault 2-0, bits 15-7 unused.
// - Register 3: capture5 14-12, capture4 10-8, capture3 6-4.
// - Register 4: only compare5 at bits 6-4 is implemented.
// - Register 5: only the parallel port field at bits 6-4.
// - Register 6: i2c2 master 10-8, slave 6-4, bits 15-11 unused.
// - After reset every source of these fields sits at level 4.
`timescale 1ns/1ps
`default_nettype none
module ipr_top
    import ipr_pkg::*;
#(
    parameter int unsigned NSRC = IPR_NSRC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire ipr_addr_t addr_i,
    input wire ipr_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output ipr_word_t rdata_o,
    output logic bad_addr_o,
    input wire logic [NSRC-1:0] src_flag_i,
    output logic [NSRC-1:0] src_req_o,
    output logic [NSRC*IPR_FW-1:0] prio_o,
    output logic req_any_o,
    output ipr_prio_t req_level_o,
    output ipr_src_t req_src_o
);

    ////////////////////////////////////////////////////////////////////
    // Internal signals

    ipr_bank_if #(.NSRC(NSRC)) bank ();

    // Write data with unimplemented bits forced low
    ipr_word_t wmask_w;
    // Word assembled for the register being read
    ipr_word_t rword_w;
    // Strobe targets a register index that does not exist
    logic bad_w;
    // Highest pending request found by the picker
    logic pick_any_w;
    ipr_prio_t pick_level_w;
    ipr_src_t pick_src_w;

    // Registered copies that drive the outputs
    ipr_word_t rdata_r;
    logic bad_addr_r;
    logic [NSRC-1:0] src_req_r;
    logic req_any_r;
    ipr_prio_t req_level_r;
    ipr_src_t req_src_r;

    ////////////////////////////////////////////////////////////////////
    // Write path

    // Mask the write word first, so a stray one in an unused bit
    // can never reach a field even if the table below is changed.
    always_comb begin
        wmask_w = wdata_i & ipr_mask(addr_i);
    end

    // Each source takes the write only when its own register is
    // addressed; the slice position comes from the placement table.
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_wr
            // Field placement per register
            assign bank.wr[g] = wr_i
                && (addr_i == ipr_addr_t'(IPR_SRC_REG[g]));
            assign bank.wval[g] =
                wmask_w[IPR_SRC_LSB[g] +: IPR_FW];
        end
    endgenerate

    // Field storage, one register per source
    ipr_prio_bank #(
        .NSRC(NSRC)
    ) u_bank (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .bank(bank.owner)
    );

    ////////////////////////////////////////////////////////////////////
    // Read path

    // Collect the fields of the addressed register into one word.
    // Bits not claimed by any field stay zero, and the mask is
    // applied again as a guard for unmapped indices.
    always_comb begin
        rword_w = 16'h0000;
        for (int i = 0; i < NSRC; i++) begin
            if (addr_i == ipr_addr_t'(IPR_SRC_REG[i])) begin
                rword_w[IPR_SRC_LSB[i] +: IPR_FW] = bank.prio[i];
            end
        end
        rword_w = rword_w & ipr_mask(addr_i);
    end

    // Read data stands only in the cycle after the read strobe and
    // is zero otherwise; an unmapped index answers zero.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_r <= 16'h0000;
        end else if (rd_i) begin
            rdata_r <= rword_w;
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Unmapped access report

    // Any strobe at index 7 is refused: a write stores nothing and a
    // read returns zero. The flag pulses for one cycle so that a
    // bus monitor can count stray accesses.
    always_comb begin
        bad_w = (wr_i || rd_i) && !ipr_mapped(addr_i);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bad_addr_r <= 1'b0;
        end else begin
            bad_addr_r <= bad_w;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Request gating

    // A source asks the arbiter only when its flag is up and its
    // priority code is not zero. The flags come from logic on this
    // clock, so they are used without synchronisers.
    generate
        for (g = 0; g < NSRC; g++) begin : g_req
            assign bank.req[g] = src_flag_i[g]
                && (bank.prio[g] != IPR_PRIO_OFF);
        end
    endgenerate

    // Registered gated requests; costs one cycle of latency but
    // keeps the long compare chain of the picker off the outputs.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            src_req_r <= '0;
        end else begin
            src_req_r <= bank.req;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Highest pending level

    // Level equals the stored code, so comparing codes as unsigned
    // numbers orders the sources from level 1 up to level 7.
    ipr_pick #(
        .NSRC(NSRC)
    ) u_pick (
        .bank(bank.view),
        .any_o(pick_any_w),
        .level_o(pick_level_w),
        .src_o(pick_src_w)
    );

    // Winner is held in flops; level and index read zero when idle.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            req_any_r <= 1'b0;
            req_level_r <= IPR_PRIO_OFF;
            req_src_r <= 4'h0;
        end else begin
            req_any_r <= pick_any_w;
            req_level_r <= pick_level_w;
            req_src_r <= pick_src_w;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    // Stored fields go out flat, source 0 in the lowest three bits;
    // they come straight from the bank flops.
    generate
        for (g = 0; g < NSRC; g++) begin : g_out
            assign prio_o[g*IPR_FW +: IPR_FW] = bank.prio[g];
        end
    endgenerate

    assign rdata_o = rdata_r;
    assign bad_addr_o = bad_addr_r;
    assign src_req_o = src_req_r;
    assign req_any_o = req_any_r;
    assign req_level_o = req_level_r;
    assign req_src_o = req_src_r;

endmodule
`default_nettype wire

// *** testbench/ipr_top_monitor.sv ***
// Checker for the priority register group, bound onto ipr_top.
// Assumes it sees only the top ports; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ipr_top_monitor
    import ipr_pkg::*;
#(
    parameter int unsigned NSRC = IPR_NSRC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire ipr_addr_t addr_i,
    input wire ipr_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire ipr_word_t rdata_o,
    input wire logic bad_addr_o,
    input wire logic [NSRC-1:0] src_flag_i,
    input wire logic [NSRC-1:0] src_req_o,
    input wire logic [NSRC*IPR_FW-1:0] prio_o,
    input wire logic req_any_o,
    input wire ipr_prio_t req_level_o,
    input wire ipr_src_t req_src_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////
    // Flags gated by a nonzero field, as the request path must see them
    logic [NSRC-1:0] gate;
    always_comb begin
        for (int s = 0; s < NSRC; s++) begin
            gate[s] = src_flag_i[s] && (prio_o[3*s+:3] != 3'h0);
        end
    end
    // Fields one cycle back, as the registered winner saw them
    logic [NSRC*IPR_FW-1:0] prio_q;
    always_ff @(posedge clk_i) begin
        prio_q <= prio_o;
    end
    // Highest pending level; scanning downwards with >= keeps the
    // lowest index on a tie
    ipr_prio_t top_lv;
    ipr_src_t top_src;
    always_comb begin
        top_lv = 3'h0;
        top_src = 4'h0;
        for (int s = NSRC - 1; s >= 0; s--) begin
            if (src_req_o[s] && prio_q[3*s+:3] >= top_lv) begin
                top_lv = prio_q[3*s+:3];
                top_src = 4'(s);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    property p_gate; src_req_o == $past(gate); endproperty
    a_gate: assert property (p_gate) else $error("gated request wrong");
    property p_any; req_any_o == (src_req_o != '0); endproperty
    a_any: assert property (p_any) else $error("any request wrong");
    property p_idle;
        !req_any_o |-> req_level_o == 3'h0 && req_src_o == 4'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("idle level wrong");
    property p_win;
        req_any_o |-> src_req_o[req_src_o]
            && req_level_o == 3'($past(prio_o) >> (3 * req_src_o));
    endproperty
    a_win: assert property (p_win) else $error("winner level wrong");
    property p_max;
        req_any_o |-> req_level_o == top_lv && req_src_o == top_src;
    endproperty
    a_max: assert property (p_max) else $error("winner not highest");
    property p_rst; $past(!rst_b_i) |-> prio_o == {NSRC{3'b100}}; endproperty
    a_rst: assert property (p_rst) else $error("reset field wrong");
    property p_hold; !wr_i |=> $stable(prio_o); endproperty
    a_hold: assert property (p_hold) else $error("field moved");
    property p_bad;
        bad_addr_o == ($past(wr_i || rd_i) && $past(addr_i) == 3'h7);
    endproperty
    a_bad: assert property (p_bad) else $error("bad index pulse wrong");
    property p_rz; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
    a_rz: assert property (p_rz) else $error("idle read data");
    property p_map0;
        wr_i && addr_i == 3'h0 |=> prio_o[8:0] ==
            {$past(wdata_i[6:4]), $past(wdata_i[10:8]), $past(wdata_i[14:12])};
    endproperty
    a_map0: assert property (p_map0) else $error("field map wrong");
    property p_b2b;
        wr_i && addr_i == 3'h1 ##1 rd_i && addr_i == 3'h1
            |=> rdata_o == ($past(wdata_i, 2) & 16'h7777);
    endproperty
    a_b2b: assert property (p_b2b) else $error("readback wrong");
    // Main scenarios reached
    c_bad: cover property (bad_addr_o);
    c_top: cover property (req_any_o && req_level_o == 3'h7);
    c_b2b: cover property (wr_i ##1 rd_i);
    c_tie: cover property (req_any_o && src_req_o[2] && src_req_o[7]);
endmodule
`default_nettype wire

// *** testbench/ipr_top_tb.sv ***
// Self-checking bench for ipr_top: register accesses and requests.
// Assumes the bench alone drives every input of the block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module ipr_top_tb;
    import ipr_pkg::*;
    logic clk_i, rst_b_i, wr_i, rd_i, bad_addr_o, req_any_o;
    logic rd_q = 1'b0;
    logic bad_q = 1'b0;
    ipr_addr_t addr_i;
    ipr_word_t wdata_i, rd_exp, exp_q, rdata_o;
    logic [IPR_NSRC-1:0] src_flag_i, src_req_o;
    logic [IPR_NSRC*IPR_FW-1:0] prio_o;
    ipr_prio_t req_level_o;
    ipr_src_t req_src_o;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    ipr_word_t msk [7] = '{16'h7770, 16'h7777, 16'h0077, 16'h7770,
        16'h0070, 16'h0070, 16'h0770};
    ipr_top #(.NSRC(IPR_NSRC)) u_ipr_top (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .bad_addr_o(bad_addr_o), .src_flag_i(src_flag_i),
        .src_req_o(src_req_o), .prio_o(prio_o), .req_any_o(req_any_o),
        .req_level_o(req_level_o), .req_src_o(req_src_o));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after the strobe edge and is
    // zero in every other cycle; an index-7 strobe pulses the flag.
    always @(posedge clk_i) begin
        if (rst_b_i) begin
            `CHK(rdata_o, rd_q ? exp_q : 16'h0000)
            `CHK(bad_addr_o, bad_q)
        end
        rd_q <= rd_i;
        exp_q <= rd_exp;
        bad_q <= (wr_i || rd_i) && (addr_i == 3'h7);
    end
    // Whole run is under 2000 cycles; this cuts a hang short
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////
    // One strobe cycle; for a read, d is the expected data
    task acc(input logic w, input ipr_addr_t a, input ipr_word_t d);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        rd_exp <= d;
        @(posedge clk_i);
    endtask
    task idle();
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task wr(input ipr_addr_t a, input ipr_word_t d);
        acc(1'b1, a, d);
        idle();
    endtask
    task rd(input ipr_addr_t a, input ipr_word_t e);
        acc(1'b0, a, e);
        idle();
    endtask
    task chk_rst();
        `CHK(prio_o, {IPR_NSRC{3'h4}})
        for (int a = 0; a < 7; a++) rd(3'(a), 16'h4444 & msk[a]);
    endtask
    // Distinct codes per field expose any misplaced field
    task fld(input ipr_addr_t a);
        wr(a, 16'h2567);
        for (int s = 0; s < IPR_NSRC; s++)
            if (IPR_SRC_REG[s] == a)
                `CHK(prio_o[3*s+:3], 3'(16'h2567 >> IPR_SRC_LSB[s]))
    endtask
    task reqchk(input logic [IPR_NSRC-1:0] e, input ipr_prio_t l,
        input ipr_src_t s);
        repeat (3) @(posedge clk_i);
        #1;
        `CHK(src_req_o, e)
        `CHK(req_any_o, |e)
        `CHK(req_level_o, l)
        `CHK(req_src_o, s)
        @(posedge clk_i);
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        rst_b_i <= 1'b0;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        addr_i <= 3'h0;
        wdata_i <= 16'h0000;
        rd_exp <= 16'h0000;
        src_flag_i <= '0;
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        chk_rst();
        $display("reset values done");
        for (int c = 0; c < 8; c++) begin
            for (int a = 0; a < 7; a++) begin
                wr(3'(a), {4{1'b1, 3'(c)}});
                rd(3'(a), {4{1'b0, 3'(c)}} & msk[a]);
            end
        end
        $display("codes and reserved bits done");
        fld(3'h0);
        fld(3'h1);
        fld(3'h2);
        fld(3'h3);
        fld(3'h4);
        fld(3'h5);
        fld(3'h6);
        acc(1'b1, 3'h1, 16'hF0F0);
        acc(1'b0, 3'h1, 16'h7070);
        acc(1'b1, 3'h7, 16'hFFFF);
        acc(1'b0, 3'h7, 16'h0000);
        idle();
        rd(3'h1, 16'h7070);
        $display("field layout done");
        for (int a = 0; a < 7; a++) wr(3'(a), 16'h0000);
        src_flag_i <= '1;
        reqchk(16'h0000, 3'h0, 4'h0);
        wr(3'h1, 16'h5000);
        reqchk(16'h0008, 3'h5, 4'h3);
        wr(3'h6, 16'h0700);
        reqchk(16'h4008, 3'h7, 4'hE);
        wr(3'h0, 16'h0010);
        src_flag_i <= 16'h0004;
        reqchk(16'h0004, 3'h1, 4'h2);
        // Equal levels: the lower source index must win
        src_flag_i <= 16'h0084;
        wr(3'h2, 16'h0010);
        reqchk(16'h0084, 3'h1, 4'h2);
        $display("request path done");
        src_flag_i <= '0;
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        chk_rst();
        $display("second reset done");
        close_out();
    end
endmodule
bind ipr_top ipr_top_monitor #(.NSRC(NSRC)) u_ipr_top_monitor (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bad_addr_o(bad_addr_o),
    .src_flag_i(src_flag_i), .src_req_o(src_req_o), .prio_o(prio_o),
    .req_any_o(req_any_o), .req_level_o(req_level_o), .req_src_o(req_src_o));
`default_nettype wire
